// ===== hw/esq_cfg.svh
// Purpose: Constants for the EEPROM command sequencer host controller.
// Assumes: 100 MHz clock, 13-bit byte address, 8-bit data.
// Notes:   Timing counts derive from printed times at the clock rate.
`ifndef ESQ_CFG_SVH
`define ESQ_CFG_SVH
`define ESQ_CLK_MHZ        100
`define ESQ_ADDR_A         13'h1555
`define ESQ_ADDR_B         13'h0AAA
`define ESQ_DAT_AA         8'hAA
`define ESQ_DAT_55         8'h55
`define ESQ_DAT_80         8'h80
`define ESQ_DAT_A0         8'hA0
`define ESQ_DAT_PROT_OFF   8'h20
`define ESQ_DAT_CLEAR      8'h10
`define ESQ_DAT_AC_OFF     8'h40
`define ESQ_DAT_AC_ON      8'h50
`define ESQ_DAT_ERASED     8'hFF
`define ESQ_PAGE_BYTES     64
// Command writes before page data: long commands and the short prefix.
`define ESQ_CMD_STEPS      3'd6
`define ESQ_PROT_STEPS     3'd3
// Index of the code word in the six-write table.
`define ESQ_CODE_STEP      3'd5
// Write strobe low time, ns (least 150) and setup/hold margin, ns.
`define ESQ_TWP_NS         150
`define ESQ_TAS_NS         100
`define ESQ_TWP_CYC        ((`ESQ_TWP_NS * `ESQ_CLK_MHZ + 999) / 1000)
`define ESQ_TAS_CYC        ((`ESQ_TAS_NS * `ESQ_CLK_MHZ + 999) / 1000)
// Byte load gap, us (longest 200), exact whole cycles.
`define ESQ_TBLC_US        200
`define ESQ_TBLC_CYC       (`ESQ_TBLC_US * `ESQ_CLK_MHZ)
// Program and clear times, ms.
`define ESQ_TWC_MS         10
`define ESQ_TWC_NOAC_MS    5
`define ESQ_TCLR_MS        20
`define ESQ_MS_CYC(ms)     ((ms) * 1000 * `ESQ_CLK_MHZ)
`endif

// ===== hw/esq_pkg.sv
// Purpose: Types for the EEPROM command sequencer host controller.
// Assumes: Constants come from esq_cfg.svh.
// Notes:   Commands travel as an enum; command words and bus bundles as packed structs.
package esq_pkg;
  typedef enum logic [2:0] {
    ESQ_CMD_PAGE,
    ESQ_CMD_PROT_ON,
    ESQ_CMD_PROT_OFF,
    ESQ_CMD_CLEAR,
    ESQ_CMD_AC_OFF,
    ESQ_CMD_AC_ON
  } esq_cmd_t;

  typedef struct packed {
    logic [12:0] addr;
    logic [7:0]  data;
  } esq_word_t;

  typedef struct packed {
    logic        ce_n;
    logic        we_n;
    logic        oe_n;
    logic [12:0] byte_address;
    logic [7:0]  dq_out;
    logic        dq_oe;
  } esq_pins_t;
endpackage

// ===== hw/esq_strobe.sv
// Purpose: Drives one write strobe on the memory bus.
// Assumes: Address and data are stable while busy is high.
// Notes:   Setup, low pulse and hold each take the counts given.
`timescale 1ns/1ps
`include "esq_cfg.svh"
module esq_strobe #(
  parameter int SETUP_CYC = `ESQ_TAS_CYC,
  parameter int PULSE_CYC = `ESQ_TWP_CYC
) (
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic start,
  output logic      busy,
  output logic      we_n,
  output logic      done
);
  typedef enum logic [1:0] {ESQ_ST_IDLE, ESQ_ST_SET, ESQ_ST_LOW,
                            ESQ_ST_HOLD} esq_st_t;
  esq_st_t     st;
  esq_st_t     next_st;
  logic [15:0] cnt;
  wire         cnt_end = (cnt == 16'h0000);

  always_comb begin
    next_st = st;
    case (st)
      ESQ_ST_IDLE: if (start) next_st = ESQ_ST_SET;
      ESQ_ST_SET:  if (cnt_end) next_st = ESQ_ST_LOW;
      ESQ_ST_LOW:  if (cnt_end) next_st = ESQ_ST_HOLD;
      ESQ_ST_HOLD: if (cnt_end) next_st = ESQ_ST_IDLE;
      default:     next_st = ESQ_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st   <= ESQ_ST_IDLE;
      cnt  <= 16'h0000;
      we_n <= 1'b1;
      done <= 1'b0;
    end else begin
      st   <= next_st;
      done <= (st == ESQ_ST_HOLD) && cnt_end;
      we_n <= !(next_st == ESQ_ST_LOW);
      if (next_st != st)
        cnt <= (next_st == ESQ_ST_LOW) ? 16'(PULSE_CYC - 1)
                                       : 16'(SETUP_CYC - 1);
      else if (!cnt_end)
        cnt <= cnt - 16'h0001;
    end
  end

  assign busy = (st != ESQ_ST_IDLE);
endmodule

// ===== hw/esq_host.sv
// Purpose: Host controller that issues command sequences and page loads
//          to a parallel page-write EEPROM with software protection.
// Assumes: One clock at 100 MHz; the memory pins are on the far side.
// Notes:   Data bytes come from a page buffer filled before each start.
//
// Overview of operation
// (R1) Protection disable: six writes ending at 1555h with 20h.
// (R2) Host sends a command sequence first, before any page data.
// (R3) Device aborts a sequence on any mismatch; host restarts from step 1.
// (R4) After disable completes, later page writes go without the prefix.
// (R5) Disable needs at least one page byte after the six writes.
// (R6) Chip clear: six writes ending at 1555h with 10h, no page data.
// (R7) Chip clear runs about 20 ms on the device's own timer.
// (R8) After clear every bit reads high.
// (R9) Autoclear disable: six writes ending 40h, then page data.
// (R10) With autoclear off the page program takes about 5 ms.
// (R11) Autoclear off persists until power-down or the enable command.
// (R12) Autoclear enable: six writes ending 50h, then page data.
// (R13) Power-down restores autoclear, the power-up default.
// (R14) Use autoclear-off writes mainly after a chip clear.
// (R15) With protection on, each page write needs the three-write prefix.
// (R16) Host loads each byte within 200 us of the previous one.
// (R17) Page bits latch at first write; byte bits pick bytes in any order.
// (R18) Command writes use ordinary data write timing.
// (R19) Device compares full address and data of each command step.
// (R20) Device ignores writes during an internal cycle; host waits.
`timescale 1ns/1ps
`include "esq_cfg.svh"
module esq_host #(
  parameter int PAGE_BYTES  = `ESQ_PAGE_BYTES,
  parameter int TBLC_CYC    = `ESQ_TBLC_CYC,
  parameter int TWC_CYC     = `ESQ_MS_CYC(`ESQ_TWC_MS),
  parameter int TWC_NOAC_CYC = `ESQ_MS_CYC(`ESQ_TWC_NOAC_MS),
  parameter int TCLR_CYC    = `ESQ_MS_CYC(`ESQ_TCLR_MS)
) (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             start,
  input  wire esq_pkg::esq_cmd_t cmd,
  input  wire logic [6:0]       page_select_bits,
  input  wire logic [6:0]       byte_count,
  input  wire logic             buf_wr,
  input  wire logic [5:0]       byte_in_page_bits,
  input  wire logic [7:0]       buf_data,
  input  wire logic             power_down,
  output esq_pkg::esq_pins_t    pins,
  output logic                  busy,
  output logic                  done,
  output logic                  prot_on,
  output logic                  autoclear_on
);
  typedef enum logic [2:0] {ESQ_H_IDLE, ESQ_H_PREFIX, ESQ_H_DATA,
                            ESQ_H_STROBE, ESQ_H_WAIT} esq_hst_t;

  function automatic esq_pkg::esq_word_t prefix_word(
    input logic [2:0] idx, input logic [7:0] last);
    case (idx)
      3'd0, 3'd3: prefix_word = '{`ESQ_ADDR_A, `ESQ_DAT_AA};
      3'd1, 3'd4: prefix_word = '{`ESQ_ADDR_B, `ESQ_DAT_55};
      3'd2:       prefix_word = '{`ESQ_ADDR_A, `ESQ_DAT_80};
      default:    prefix_word = '{`ESQ_ADDR_A, last};
    endcase
  endfunction

  // Code word that closes each six-write command; A0h closes the prefix.
  function automatic logic [7:0] cmd_code(input esq_pkg::esq_cmd_t c);
    case (c)
      esq_pkg::ESQ_CMD_PROT_OFF: cmd_code = `ESQ_DAT_PROT_OFF;      // [R1]
      esq_pkg::ESQ_CMD_CLEAR:    cmd_code = `ESQ_DAT_CLEAR;         // [R6]
      esq_pkg::ESQ_CMD_AC_OFF:   cmd_code = `ESQ_DAT_AC_OFF;        // [R9]
      esq_pkg::ESQ_CMD_AC_ON:    cmd_code = `ESQ_DAT_AC_ON;         // [R12]
      default:                   cmd_code = `ESQ_DAT_A0;
    endcase
  endfunction

  logic [7:0]          page_mem [PAGE_BYTES];
  esq_hst_t            st;
  esq_hst_t            back_st;
  esq_pkg::esq_cmd_t   cur_cmd;
  logic [2:0]          step;
  logic [6:0]          bidx;
  logic [6:0]          nbytes;
  logic [6:0]          page;
  logic [31:0]         wait_cnt;
  esq_pkg::esq_word_t  word;
  logic                stb_start;
  logic                stb_busy;
  logic                stb_we_n;
  logic                stb_done;

  // Three-write prefix for protected pages and protection enable, six-write for other commands.
  wire       long_cmd  = (cur_cmd != esq_pkg::ESQ_CMD_PAGE) &&
                         (cur_cmd != esq_pkg::ESQ_CMD_PROT_ON);
  wire [2:0] pre_len   = long_cmd ? `ESQ_CMD_STEPS :
                         ((prot_on || cur_cmd == esq_pkg::ESQ_CMD_PROT_ON)
                          ? `ESQ_PROT_STEPS : 3'd0);     // [R4] [R15]
  wire [7:0] last_dat  = cmd_code(cur_cmd);
  wire [2:0] pre_idx   = long_cmd ? step :
                         ((step == 3'd2) ? `ESQ_CODE_STEP : step);
  wire esq_pkg::esq_word_t pre_word = prefix_word(pre_idx, last_dat);
  // Counts above a page would wrap onto bytes already sent.
  wire [6:0] load_cnt  = (byte_count > 7'(PAGE_BYTES)) ? 7'(PAGE_BYTES)
                                                      : byte_count;
  // Clear loads no page data; others load at least one byte.
  wire [6:0] eff_bytes = (cmd == esq_pkg::ESQ_CMD_CLEAR) ? 7'd0 :
                         ((load_cnt == 7'd0) ? 7'd1 : load_cnt);    // [R5]
  // Clear is waited out in full so later reads see the erased array.
  wire [31:0] cyc_time =
    (cur_cmd == esq_pkg::ESQ_CMD_CLEAR) ? 32'(TCLR_CYC) :     // [R7] [R8]
    autoclear_on ? 32'(TWC_CYC) : 32'(TWC_NOAC_CYC);               // [R10]
  wire [5:0] bsel      = bidx[5:0];
  // Device state flags follow the command only once its cycle is over.
  wire       op_end    = (st == ESQ_H_WAIT) && (wait_cnt == 32'h0000_0000);

  esq_strobe u_stb (
    .clk   (clk),
    .rstn  (rstn),
    .start (stb_start),
    .busy  (stb_busy),
    .we_n  (stb_we_n),
    .done  (stb_done)
  );

  always_ff @(posedge clk) begin
    if (buf_wr && st == ESQ_H_IDLE)
      page_mem[byte_in_page_bits] <= buf_data;                     // [R17]
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prot_on      <= 1'b0;
      autoclear_on <= 1'b1;
    end else begin
      if (op_end && cur_cmd == esq_pkg::ESQ_CMD_PROT_ON)
        prot_on <= 1'b1;                                 // [R15]
      else if (op_end && cur_cmd == esq_pkg::ESQ_CMD_PROT_OFF)
        prot_on <= 1'b0;                                 // [R4]
      // Supply loss wins over an autoclear command ending this cycle.
      if (power_down)
        autoclear_on <= 1'b1;                            // [R13]
      else if (op_end && cur_cmd == esq_pkg::ESQ_CMD_AC_OFF)
        autoclear_on <= 1'b0;                            // [R11]
      else if (op_end && cur_cmd == esq_pkg::ESQ_CMD_AC_ON)
        autoclear_on <= 1'b1;                            // [R12]
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st           <= ESQ_H_IDLE;
      back_st      <= ESQ_H_IDLE;
      cur_cmd      <= esq_pkg::ESQ_CMD_PAGE;
      step         <= 3'd0;
      bidx         <= 7'd0;
      nbytes       <= 7'd0;
      page         <= 7'd0;
      wait_cnt     <= 32'h0000_0000;
      word         <= '0;
      stb_start    <= 1'b0;
      busy         <= 1'b0;
      done         <= 1'b0;
      pins         <= '{1'b1, 1'b1, 1'b1, 13'h0000, 8'h00, 1'b0};
    end else begin
      stb_start <= 1'b0;
      done      <= 1'b0;
      pins.we_n <= stb_we_n;
      case (st)
        ESQ_H_IDLE: if (start) begin
          cur_cmd <= cmd;
          page    <= page_select_bits;
          nbytes  <= eff_bytes;
          step    <= 3'd0;                                         // [R3]
          bidx    <= 7'd0;
          busy    <= 1'b1;
          st      <= ESQ_H_PREFIX;                                 // [R2]
        end
        ESQ_H_PREFIX: begin
          if (step < pre_len) begin
            word    <= pre_word;                                   // [R18]
            step    <= step + 3'd1;
            back_st <= ESQ_H_PREFIX;
            st      <= ESQ_H_STROBE;
          end else
            st <= ESQ_H_DATA;
        end
        ESQ_H_DATA: begin
          if (bidx < nbytes) begin
            word    <= '{{page, bsel}, page_mem[bsel]};            // [R17]
            bidx    <= bidx + 7'd1;
            back_st <= ESQ_H_DATA;
            st      <= ESQ_H_STROBE;
          end else begin
            wait_cnt <= cyc_time;
            st       <= ESQ_H_WAIT;
          end
        end
        ESQ_H_STROBE: begin
          pins.ce_n         <= 1'b0;
          pins.dq_oe        <= 1'b1;
          pins.byte_address <= word.addr;                          // [R19]
          pins.dq_out       <= word.data;
          if (!stb_busy && !stb_start && pins.ce_n)
            stb_start <= 1'b1;
          if (stb_done) begin
            pins.ce_n  <= 1'b1;
            pins.dq_oe <= 1'b0;
            st         <= back_st;        // Next byte well inside [R16].
          end
        end
        ESQ_H_WAIT: begin
          // No strobes while the device runs its own cycle.
          if (wait_cnt != 32'h0000_0000)
            wait_cnt <= wait_cnt - 32'h0000_0001;                  // [R20]
          else begin
            busy <= 1'b0;
            done <= 1'b1;
            st   <= ESQ_H_IDLE;
          end
        end
        default: st <= ESQ_H_IDLE;
      endcase
    end
  end
endmodule

// ===== testbench/esq_host_sva.sv
// Purpose: Port checker for the EEPROM host controller.
// Assumes: One clock; rstn is asynchronous and active low.
// Notes:   Strobe width is counted in helper logic.
`timescale 1ns/1ps
`include "esq_cfg.svh"
module esq_host_sva (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic               start,
  input wire logic               busy,
  input wire logic               done,
  input wire logic               power_down,
  input wire logic               prot_on,
  input wire logic               autoclear_on,
  input wire esq_pkg::esq_pins_t pins
);
  localparam int TWP = `ESQ_TWP_CYC;
  logic [7:0] low_cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn)
      low_cnt <= 8'h00;
    else if (pins.we_n)
      low_cnt <= 8'h00;
    else
      low_cnt <= low_cnt + 8'h01;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_strobe;
    !pins.we_n;
  endsequence
  sequence s_take;
    start && !busy;
  endsequence
  a_we_in_ce: assert property (s_strobe |->
    !pins.ce_n && pins.dq_oe && pins.oe_n)
    else $error("write strobe outside a driven chip select");
  a_latch_stable: assert property (s_strobe |=>
    $stable(pins.byte_address) && $stable(pins.dq_out) && pins.dq_oe)
    else $error("address or data moved under the strobe");
  a_pulse_width: assert property ($rose(pins.we_n) |-> low_cnt >= TWP)
    else $error("write strobe too short");
  a_ce_hold: assert property ($rose(pins.we_n) |-> !pins.ce_n)
    else $error("chip select released before strobe end");
  a_start_busy: assert property (s_take |=> busy)
    else $error("start not taken");
  a_done_single: assert property (done |=> !done)
    else $error("done longer than one cycle");
  a_idle_quiet: assert property (!busy && !done |-> pins.we_n && pins.ce_n)
    else $error("bus active while idle");
  a_power_ac: assert property (power_down |=> autoclear_on)
    else $error("power down did not restore autoclear");
  a_flag_hold: assert property (!busy && !done && !power_down
    |=> $stable(prot_on) && $stable(autoclear_on))
    else $error("state flag changed while idle");
endmodule
bind esq_host esq_host_sva u_esq_host_sva (.clk(clk), .rstn(rstn),
  .start(start), .busy(busy), .done(done), .power_down(power_down),
  .prot_on(prot_on), .autoclear_on(autoclear_on), .pins(pins));

// ===== testbench/esq_dev_model.sv
// Purpose: Behavioural EEPROM device on the far side of the host.
// Assumes: A write latches on the rise of we_n with ce_n low.
// Notes:   Times are shortened; the bench reads state by hierarchy.
`timescale 1ns/1ps
`include "esq_cfg.svh"
module esq_dev_model #(
  parameter int LOAD_NS = 400,
  parameter int PROG_NS = 300,
  parameter int NOAC_NS = 150,
  parameter int CLR_NS  = 500
) (
  input wire esq_pkg::esq_pins_t pins,
  input wire logic               power_down
);
  localparam logic [20:0] S1 = {`ESQ_ADDR_A, `ESQ_DAT_AA};
  localparam logic [20:0] S2 = {`ESQ_ADDR_B, `ESQ_DAT_55};
  localparam logic [20:0] S3 = {`ESQ_ADDR_A, `ESQ_DAT_80};
  logic [7:0]  mem [8192];
  logic [7:0]  pbuf [64];
  logic [63:0] pmask = '0;
  logic [6:0]  page;
  logic [7:0]  pend = '0;
  int          st = 0, late = 0, clears = 0, last_prog = 0;
  logic        prot = 1'b0, ac = 1'b1, unlk = 1'b0, dev_busy = 1'b0;
  realtime     t_last = 0;
  initial foreach (mem[i]) mem[i] = 8'h00;
  always @(posedge power_down) ac = 1'b1;
  always @(posedge pins.we_n) begin
    if (!pins.ce_n && dev_busy)
      late++;
    else if (!pins.ce_n)
      step({pins.byte_address, pins.dq_out});
  end
  task automatic step(input logic [20:0] w);
    logic [20:0] exp;
    exp = (st == 1 || st == 4) ? S2 : (st == 2) ? S3 : S1;
    t_last = $realtime;
    if (st == 2 && w == {`ESQ_ADDR_A, `ESQ_DAT_A0}) begin
      st = 0;
      unlk = 1'b1;
      pend = w[7:0];
    end else if (st == 5 && w[20:8] == `ESQ_ADDR_A && w[7:0] inside
      {8'h20, 8'h10, 8'h40, 8'h50}) begin
      st = 0;
      pend = w[7:0];
      unlk = (w[7:0] != `ESQ_DAT_CLEAR);
      if (w[7:0] == `ESQ_DAT_CLEAR) begin
        foreach (mem[i]) mem[i] = `ESQ_DAT_ERASED;
        clears++;
        dev_busy = 1'b1;
        dev_busy <= #(CLR_NS) 1'b0;
      end
    end else if (st < 5 && w == exp && !(st == 0 && pmask != '0)) begin
      st++;
    end else begin
      st = 0;
      if (pmask == '0)
        page = w[20:14];
      pbuf[w[13:8]] = w[7:0];
      pmask[w[13:8]] = 1'b1;
    end
  endtask
  // A page is committed only once the load window has lapsed.
  always begin
    wait (pmask != '0);
    while ($realtime - t_last < LOAD_NS) #10;
    if (!prot || unlk)
      foreach (pbuf[i]) if (pmask[i]) mem[{page, 6'(i)}] = pbuf[i];
    if (pend == `ESQ_DAT_A0) prot = 1'b1;
    if (pend == `ESQ_DAT_PROT_OFF) prot = 1'b0;
    if (pend == `ESQ_DAT_AC_OFF) ac = 1'b0;
    if (pend == `ESQ_DAT_AC_ON) ac = 1'b1;
    last_prog = ac ? PROG_NS : NOAC_NS;
    {pmask, pend, unlk, dev_busy} = {64'h0, 8'h00, 1'b0, 1'b1};
    #(last_prog);
    dev_busy = 1'b0;
  end
endmodule

// ===== testbench/esq_host_bench.sv
// Purpose: Self-checking bench for the EEPROM host controller.
// Assumes: esq_dev_model stands in for the memory device.
// Notes:   Host waits are shortened but stay above the model's times.
`timescale 1ns/1ps
module esq_host_bench;
  localparam int NOAC = 150;
  logic               clk, rstn, start, buf_wr, power_down;
  esq_pkg::esq_cmd_t  cmd;
  logic [6:0]         page_select_bits, byte_count;
  logic [5:0]         byte_in_page_bits;
  logic [7:0]         buf_data;
  esq_pkg::esq_pins_t pins;
  logic               busy, done, prot_on, autoclear_on;
  int                 fails = 0, num_checks = 0, cycles = 0;
  esq_host #(.TBLC_CYC(50), .TWC_CYC(120), .TWC_NOAC_CYC(80),
    .TCLR_CYC(120)) u_esq_host (.clk(clk), .rstn(rstn), .start(start),
    .cmd(cmd), .page_select_bits(page_select_bits),
    .byte_count(byte_count), .buf_wr(buf_wr),
    .byte_in_page_bits(byte_in_page_bits), .buf_data(buf_data),
    .power_down(power_down), .pins(pins), .busy(busy), .done(done),
    .prot_on(prot_on), .autoclear_on(autoclear_on));
  esq_dev_model #(.NOAC_NS(NOAC)) u_dev (.pins(pins),
    .power_down(power_down));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      fails++;
      test_done;
    end
  end
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  function automatic logic [7:0] pat(input logic [6:0] pg, input int i);
    return {pg[1:0], 6'(i)} ^ 8'h5A;
  endfunction
  task automatic chk_mem(input logic [6:0] pg, input logic [5:0] i);
    chk("mem", u_dev.mem[{pg, i}], pat(pg, i));
  endtask
  task automatic op(input esq_pkg::esq_cmd_t c, input logic [6:0] pg, n);
    int k;
    for (k = 0; k < n; k++) begin
      buf_wr = 1'b1;
      byte_in_page_bits = 6'(k);
      buf_data = pat(pg, k);
      tick;
    end
    {buf_wr, cmd, page_select_bits} = {1'b0, c, pg};
    {byte_count, start} = {n, 1'b1};
    tick;
    start = 1'b0;
    chk("busy", busy, 1'b1);
    for (k = 0; k < 5000 && done !== 1'b1; k++) tick;
    chk("done", done, 1'b1);
    chk("busy", busy, 1'b0);
    tick;
  endtask
  task automatic t_prot_on;
    chk("ce_n", pins.ce_n, 1'b1);
    chk("prot", prot_on, 1'b0);
    op(esq_pkg::ESQ_CMD_PROT_ON, 7'h03, 7'h02);
    chk("dev_prot", u_dev.prot, 1'b1);
    chk("prot", prot_on, 1'b1);
    chk_mem(7'h03, 6'h01);
    op(esq_pkg::ESQ_CMD_PAGE, 7'h05, 7'h40);
    chk_mem(7'h05, 6'h3F);
    chk_mem(7'h05, 6'h00);
    $display("test prot_on done");
  endtask
  task automatic t_prot_off;
    op(esq_pkg::ESQ_CMD_PROT_OFF, 7'h06, 7'h00);
    chk("dev_prot", u_dev.prot, 1'b0);
    chk("prot", prot_on, 1'b0);
    op(esq_pkg::ESQ_CMD_PAGE, 7'h07, 7'h01);
    chk_mem(7'h07, 6'h00);
    $display("test prot_off done");
  endtask
  task automatic t_clear;
    op(esq_pkg::ESQ_CMD_CLEAR, 7'h00, 7'h01);
    chk("clears", u_dev.clears, 1);
    chk("erased", u_dev.mem[13'h017F], 8'hFF);
    chk("erased", u_dev.mem[13'h1FFF], 8'hFF);
    $display("test clear done");
  endtask
  task automatic t_autoclear;
    chk("ac", autoclear_on, 1'b1);
    op(esq_pkg::ESQ_CMD_AC_OFF, 7'h08, 7'h01);
    chk("dev_ac", u_dev.ac, 1'b0);
    chk("ac", autoclear_on, 1'b0);
    op(esq_pkg::ESQ_CMD_PAGE, 7'h09, 7'h01);
    chk("prog", u_dev.last_prog, NOAC);
    chk("dev_ac", u_dev.ac, 1'b0);
    op(esq_pkg::ESQ_CMD_AC_ON, 7'h0A, 7'h01);
    chk("dev_ac", u_dev.ac, 1'b1);
    op(esq_pkg::ESQ_CMD_AC_OFF, 7'h08, 7'h01);
    power_down = 1'b1;
    tick;
    power_down = 1'b0;
    tick;
    chk("ac", autoclear_on, 1'b1);
    chk("dev_ac", u_dev.ac, 1'b1);
    chk("late", u_dev.late, 0);
    $display("test autoclear done");
  endtask
  task automatic test_done;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    {start, buf_wr, power_down, rstn} = 4'h0;
    cmd = esq_pkg::ESQ_CMD_PAGE;
    {page_select_bits, byte_count} = 14'h0000;
    {byte_in_page_bits, buf_data} = 14'h0000;
    repeat (6) @(posedge clk);
    #1 rstn = 1'b1;
    t_prot_on;
    t_prot_off;
    // Autoclear-off pages follow the clear so no stale bits remain.
    t_clear;
    t_autoclear;
    test_done;
  end
endmodule
